// file: ltra_pkg.sv
package ltra_pkg;
    localparam int TRN_AW     = 21;
    localparam int DEVAD_LSB  = 16;
    localparam int DEVAD_W    = 5;
    localparam int DW         = 16;
    localparam int CFG_AW     = 16;
    // device address of the management register space
    localparam logic [4:0] MGMT_DEVAD = 5'h01;
    localparam int CORE_CTRL_IDX = 0;
    localparam int CORE_STAT_IDX = 1;
    // controller register map on apb
    localparam logic [7:0] REG_CMD    = 8'h00;
    localparam logic [7:0] REG_ADDR   = 8'h04;
    localparam logic [7:0] REG_WDATA  = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_RDATA  = 8'h10;
    localparam int CMD_GO   = 0;
    localparam int CMD_RNW  = 1;
    localparam int CMD_CORE = 2;
    localparam int CMD_XCVR = 3;
    localparam int ST_BUSY  = 0;
    localparam int ST_DONE  = 1;
    localparam logic [15:0] RST_DATA = 16'h0000;

    typedef enum logic [1:0] {
        D_IDLE = 2'b00,
        D_REQ  = 2'b01,
        D_WAIT = 2'b10
    } ltra_dev_st_e;

    typedef enum logic [1:0] {
        C_IDLE  = 2'b00,
        C_SETUP = 2'b01,
        C_WAIT  = 2'b10
    } ltra_ctl_st_e;
endpackage

// file: ltra_link_if.sv
`timescale 1ns/1ps
interface ltra_link_if (
    input wire logic pclk,
    input wire logic presetn
);
    import ltra_pkg::*;
    // training access port
    logic              trn_enable;
    logic [TRN_AW-1:0] trn_addr;
    logic              trn_rnw;
    logic              trn_core_cs;
    logic              trn_xcvr_cs;
    logic [DW-1:0]     trn_wrdata;
    logic [DW-1:0]     trn_rddata;
    logic              trn_rdack;
    logic              trn_wrack;
    // config port ownership
    logic              cfg_req;
    logic              cfg_gnt;
    // core_side_cfg_port
    logic [CFG_AW-1:0] core_cfg_addr;
    logic [DW-1:0]     core_cfg_wdata;
    logic              core_cfg_en;
    logic              core_cfg_we;
    logic [DW-1:0]     core_cfg_rdata;
    logic              core_cfg_rdy;
    // xcvr_side_cfg_port
    logic [CFG_AW-1:0] xcvr_cfg_addr;
    logic [DW-1:0]     xcvr_cfg_wdata;
    logic              xcvr_cfg_en;
    logic              xcvr_cfg_we;
    logic [DW-1:0]     xcvr_cfg_rdata;
    logic              xcvr_cfg_rdy;

    modport dev (
        input  pclk, presetn,
        input  trn_enable, trn_addr, trn_rnw, trn_core_cs, trn_xcvr_cs,
        input  trn_wrdata,
        output trn_rddata, trn_rdack, trn_wrack,
        output cfg_req, core_cfg_addr, core_cfg_wdata, core_cfg_en,
        output core_cfg_we,
        input  cfg_gnt, core_cfg_rdata, core_cfg_rdy,
        input  xcvr_cfg_addr, xcvr_cfg_wdata, xcvr_cfg_en, xcvr_cfg_we,
        output xcvr_cfg_rdata, xcvr_cfg_rdy
    );
    modport ctl (
        input  pclk, presetn,
        output trn_enable, trn_addr, trn_rnw, trn_core_cs, trn_xcvr_cs,
        output trn_wrdata,
        input  trn_rddata, trn_rdack, trn_wrack,
        input  cfg_req, core_cfg_addr, core_cfg_wdata, core_cfg_en,
        input  core_cfg_we,
        output cfg_gnt, core_cfg_rdata, core_cfg_rdy,
        output xcvr_cfg_addr, xcvr_cfg_wdata, xcvr_cfg_en, xcvr_cfg_we,
        input  xcvr_cfg_rdata, xcvr_cfg_rdy
    );
endinterface

// file: ltra_dev.sv
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module ltra_dev #(
    parameter bit HAS_MGMT  = 1'b1,
    parameter int CORE_REGS = 16,
    parameter int XCVR_REGS = 16
) (
    ltra_link_if.dev                  lk,
    input  wire logic [ltra_pkg::DW-1:0] core_stat,
    output logic [ltra_pkg::DW-1:0]      core_ctrl
);
    import ltra_pkg::*;

    localparam int CIW = $clog2(CORE_REGS);
    localparam int XIW = $clog2(XCVR_REGS);

    // register files must be powers of two and hold control and status
    if (CORE_REGS < 2 || CORE_REGS != (1 << CIW)) begin : g_chk_core
        $error("ltra_dev: CORE_REGS must be a power of two >= 2");
    end
    if (XCVR_REGS < 2 || XCVR_REGS != (1 << XIW)) begin : g_chk_xcvr
        $error("ltra_dev: XCVR_REGS must be a power of two >= 2");
    end

    typedef struct packed {
        ltra_dev_st_e                    st;
        logic                            en_q;
        logic                            rnw;
        logic [DW-1:0]                   rddata;
        logic                            rdack;
        logic                            wrack;
        logic                            cfg_req;
        logic                            cfg_en;
        logic                            cfg_we;
        logic [CFG_AW-1:0]               cfg_addr;
        logic [DW-1:0]                   cfg_wdata;
        logic [CORE_REGS-1:0][DW-1:0]    core;
        logic [XCVR_REGS-1:0][DW-1:0]    xregs;
        logic [DW-1:0]                   x_rdata;
        logic                            x_rdy;
    } ltra_dev_s;

    ltra_dev_s s;
    ltra_dev_s next_s;

    logic [CIW-1:0] cidx;
    logic [XIW-1:0] xidx;
    logic           devad_ok;
    logic           edge_seen;

    ////////////////////////////////////////////////////////////////////////
    // address decode
    assign cidx      = lk.trn_addr[CIW-1:0];
    assign xidx      = lk.xcvr_cfg_addr[XIW-1:0];
    assign devad_ok  = lk.trn_addr[DEVAD_LSB +: DEVAD_W] == MGMT_DEVAD;
    assign edge_seen = lk.trn_enable && !s.en_q;

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        next_s        = s;
        next_s.en_q   = lk.trn_enable;
        // acks and strobes last a single cycle
        next_s.rdack  = 1'b0;
        next_s.wrack  = 1'b0;
        next_s.cfg_en = 1'b0;
        next_s.cfg_we = 1'b0;
        next_s.x_rdy  = 1'b0;
        unique case (s.st)
            D_IDLE: begin
                if (edge_seen && lk.trn_core_cs && HAS_MGMT) begin
                    // foreign device address: read zero, write dropped
                    if (lk.trn_rnw) begin
                        next_s.rddata = devad_ok ? s.core[cidx] : RST_DATA;
                        next_s.rdack  = 1'b1;
                    end else begin
                        if (devad_ok &&
                            cidx != CIW'(CORE_STAT_IDX)) begin
                            next_s.core[cidx] = lk.trn_wrdata;
                        end
                        next_s.wrack = 1'b1;
                    end
                end else if (edge_seen && lk.trn_xcvr_cs) begin
                    next_s.st        = D_REQ;
                    next_s.cfg_req   = 1'b1;
                    next_s.rnw       = lk.trn_rnw;
                    next_s.cfg_addr  = lk.trn_addr[CFG_AW-1:0];
                    next_s.cfg_wdata = lk.trn_wrdata;
                end
            end
            D_REQ: begin
                // no enable may leave before the port is owned
                if (lk.cfg_gnt) begin
                    next_s.cfg_en = 1'b1;
                    next_s.cfg_we = !s.rnw;
                    next_s.st     = D_WAIT;
                end
            end
            D_WAIT: begin
                // request held until the answer returns
                if (lk.core_cfg_rdy) begin
                    next_s.cfg_req = 1'b0;
                    next_s.st      = D_IDLE;
                    if (s.rnw) begin
                        next_s.rddata = lk.core_cfg_rdata;
                        next_s.rdack  = 1'b1;
                    end else begin
                        next_s.wrack  = 1'b1;
                    end
                end
            end
            default: begin
                next_s.st = D_IDLE;
            end
        endcase
        // status register always mirrors the live input
        next_s.core[CORE_STAT_IDX] = core_stat;
        // transceiver register file behind the transceiver-side port
        if (lk.xcvr_cfg_en) begin
            next_s.x_rdy = 1'b1;
            if (lk.xcvr_cfg_we) begin
                next_s.xregs[xidx] = lk.xcvr_cfg_wdata;
            end else begin
                next_s.x_rdata = s.xregs[xidx];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register, config port on the same clock
    always_ff @(posedge lk.pclk or negedge lk.presetn) begin
        if (!lk.presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, all straight from flops
    assign lk.trn_rddata     = s.rddata;
    assign lk.trn_rdack      = s.rdack;
    assign lk.trn_wrack      = s.wrack;
    assign lk.cfg_req        = s.cfg_req;
    assign lk.core_cfg_addr  = s.cfg_addr;
    assign lk.core_cfg_wdata = s.cfg_wdata;
    assign lk.core_cfg_en    = s.cfg_en;
    assign lk.core_cfg_we    = s.cfg_we;
    assign lk.xcvr_cfg_rdata = s.x_rdata;
    assign lk.xcvr_cfg_rdy   = s.x_rdy;
    assign core_ctrl         = s.core[CORE_CTRL_IDX];
endmodule

// file: ltra_ctl.sv
`timescale 1ns/1ps
module ltra_ctl (
    ltra_link_if.ctl           lk,
    input  wire logic [7:0]    paddr,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [31:0]   pwdata,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr
);
    import ltra_pkg::*;

    typedef struct packed {
        ltra_ctl_st_e      st;
        logic [31:0]       prdata;
        logic              pready;
        logic              rnw;
        logic              core_sel;
        logic              xcvr_sel;
        logic [TRN_AW-1:0] addr;
        logic [DW-1:0]     wdata;
        logic [DW-1:0]     rdata;
        logic              done;
        logic              t_en;
        logic              t_core;
        logic              t_xcvr;
        // arbiter stage
        logic              gnt;
        logic [CFG_AW-1:0] x_addr;
        logic [DW-1:0]     x_wdata;
        logic              x_en;
        logic              x_we;
        logic [DW-1:0]     c_rdata;
        logic              c_rdy;
    } ltra_ctl_s;

    ltra_ctl_s s;
    ltra_ctl_s next_s;
    logic      wr;
    logic      busy;

    ////////////////////////////////////////////////////////////////////////
    // apb write takes effect at the access edge only
    assign wr   = psel && penable && s.pready && pwrite;
    assign busy = s.st != C_IDLE;

    always_comb begin
        next_s        = s;
        next_s.pready = psel && !penable;
        // read data prepared during the setup cycle
        if (psel && !penable) begin
            unique case (paddr)
                REG_CMD:    next_s.prdata = {28'h0, s.xcvr_sel, s.core_sel,
                                             s.rnw, 1'b0};
                REG_ADDR:   next_s.prdata = {11'h0, s.addr};
                REG_WDATA:  next_s.prdata = {16'h0, s.wdata};
                REG_STATUS: next_s.prdata = {30'h0, s.done, busy};
                REG_RDATA:  next_s.prdata = {16'h0, s.rdata};
                default:    next_s.prdata = 32'h0;
            endcase
        end
        // settings frozen while an access is in flight
        if (wr && !busy) begin
            unique case (paddr)
                REG_CMD: begin
                    next_s.rnw      = pwdata[CMD_RNW];
                    next_s.core_sel = pwdata[CMD_CORE];
                    next_s.xcvr_sel = pwdata[CMD_XCVR];
                    if (pwdata[CMD_GO]) begin
                        next_s.done   = 1'b0;
                        next_s.st     = C_SETUP;
                        next_s.t_core = pwdata[CMD_CORE];
                        next_s.t_xcvr = pwdata[CMD_XCVR];
                    end
                end
                REG_ADDR:  next_s.addr  = pwdata[TRN_AW-1:0];
                REG_WDATA: next_s.wdata = pwdata[DW-1:0];
                default: ;
            endcase
        end
        ////////////////////////////////////////////////////////////////////
        // training engine sequencer
        unique case (s.st)
            C_IDLE: ;
            C_SETUP: begin
                // selects settle one cycle ahead of the enable edge
                next_s.t_en = 1'b1;
                next_s.st   = C_WAIT;
            end
            C_WAIT: begin
                if (lk.trn_rdack || lk.trn_wrack) begin
                    if (lk.trn_rdack) begin
                        next_s.rdata = lk.trn_rddata;
                    end
                    // strobe and both selects low before the next access
                    next_s.t_en   = 1'b0;
                    next_s.t_core = 1'b0;
                    next_s.t_xcvr = 1'b0;
                    next_s.done   = 1'b1;
                    next_s.st     = C_IDLE;
                end
            end
            default: next_s.st = C_IDLE;
        endcase
        ////////////////////////////////////////////////////////////////////
        // single-owner arbiter: grant follows request, port passes through
        next_s.gnt     = lk.cfg_req;
        next_s.x_addr  = lk.core_cfg_addr;
        next_s.x_wdata = lk.core_cfg_wdata;
        next_s.x_en    = lk.core_cfg_en && s.gnt;
        next_s.x_we    = lk.core_cfg_we && s.gnt;
        next_s.c_rdata = lk.xcvr_cfg_rdata;
        next_s.c_rdy   = lk.xcvr_cfg_rdy;
    end

    always_ff @(posedge lk.pclk or negedge lk.presetn) begin
        if (!lk.presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign prdata            = s.prdata;
    assign pready            = s.pready;
    assign pslverr           = 1'b0;
    assign lk.trn_enable     = s.t_en;
    assign lk.trn_addr       = s.addr;
    assign lk.trn_rnw        = s.rnw;
    assign lk.trn_core_cs    = s.t_core;
    assign lk.trn_xcvr_cs    = s.t_xcvr;
    assign lk.trn_wrdata     = s.wdata;
    assign lk.cfg_gnt        = s.gnt;
    assign lk.xcvr_cfg_addr  = s.x_addr;
    assign lk.xcvr_cfg_wdata = s.x_wdata;
    assign lk.xcvr_cfg_en    = s.x_en;
    assign lk.xcvr_cfg_we    = s.x_we;
    assign lk.core_cfg_rdata = s.c_rdata;
    assign lk.core_cfg_rdy   = s.c_rdy;
endmodule

// file: ltra_checker.sv
`timescale 1ns/1ps
module ltra_checker
    import ltra_pkg::*;
(
    input wire logic                        pclk,
    input wire logic                        presetn,
    input wire logic                        trn_enable,
    input wire logic                        trn_core_cs,
    input wire logic                        trn_xcvr_cs,
    input wire logic                        trn_rnw,
    input wire logic [ltra_pkg::DW-1:0]     trn_rddata,
    input wire logic                        trn_rdack,
    input wire logic                        trn_wrack,
    input wire logic                        cfg_req,
    input wire logic                        cfg_gnt,
    input wire logic [ltra_pkg::CFG_AW-1:0] core_cfg_addr,
    input wire logic                        core_cfg_en,
    input wire logic                        core_cfg_we,
    input wire logic                        core_cfg_rdy,
    input wire logic [ltra_pkg::CFG_AW-1:0] xcvr_cfg_addr,
    input wire logic                        xcvr_cfg_en,
    input wire logic                        xcvr_cfg_rdy
);
    import ltra_pkg::*;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    ////////////////////////////////////////////////////////////////////////
    // steps of a transceiver access: claim, grant, then enable
    sequence xcvr_start_s;
        $rose(trn_enable) && trn_xcvr_cs && !trn_core_cs;
    endsequence
    sequence claim_s;
        cfg_req ##1 cfg_gnt ##1 core_cfg_en;
    endsequence
    sequence core_start_s;
        $rose(trn_enable) && trn_core_cs;
    endsequence

    ////////////////////////////////////////////////////////////////////////
    xcvr_claim_a: assert property (xcvr_start_s |=> claim_s)
        else $error("transceiver access did not claim the port");
    core_ack_a: assert property (core_start_s |=>
        trn_rdack || trn_wrack)
        else $error("core access not acknowledged next cycle");
    gnt_first_a: assert property (core_cfg_en |-> cfg_gnt)
        else $error("config enable without grant");
    req_hold_a: assert property (cfg_req && !core_cfg_rdy |=> cfg_req)
        else $error("request dropped before ready");
    en_we_pair_a: assert property (core_cfg_we |-> core_cfg_en)
        else $error("write enable without access enable");
    xcvr_answer_a: assert property (xcvr_cfg_en |=> xcvr_cfg_rdy)
        else $error("transceiver side ready missing");
    rd_ack_a: assert property (core_cfg_rdy && trn_rnw |=>
        trn_rdack && !trn_wrack)
        else $error("read acknowledge missing after ready");
    wr_ack_a: assert property (core_cfg_rdy && !trn_rnw |=>
        trn_wrack && !trn_rdack)
        else $error("write acknowledge missing after ready");
    ack_pulse_a: assert property ((trn_rdack || trn_wrack) |=>
        !(trn_rdack || trn_wrack))
        else $error("acknowledge longer than a cycle");
    rddata_hold_a: assert property ($changed(trn_rddata) |-> trn_rdack)
        else $error("read data changed without acknowledge");
    gnt_follow_a: assert property (cfg_req |=> cfg_gnt)
        else $error("grant did not follow request");
    drop_between_a: assert property ((trn_rdack || trn_wrack) |->
        ##[1:2] (!trn_enable && !trn_core_cs && !trn_xcvr_cs))
        else $error("strobe or selects not dropped after acknowledge");
    pass_addr_a: assert property (xcvr_cfg_en |->
        xcvr_cfg_addr == core_cfg_addr)
        else $error("config address not passed");
    // ready from the transceiver side must come back to the core side
    rdy_return_a: assert property (xcvr_cfg_rdy |=> core_cfg_rdy)
        else $error("ready not returned to core side");
endmodule

// file: tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import ltra_pkg::*;
    logic          pclk = 1'b0;
    logic          presetn;
    logic [7:0]    paddr;
    logic          psel, penable, pwrite, pready, pslverr;
    logic [31:0]   pwdata, prdata, c;
    logic [DW-1:0] core_stat, core_ctrl;
    logic [DW-1:0] core_m [16];
    logic [DW-1:0] xcvr_m [16];
    int            miscompares, n_checks, cycles, acks, seed;

    // 250 MHz
    always #2 pclk = ~pclk;

    ltra_link_if lk (.pclk(pclk), .presetn(presetn));
    ltra_dev #(.HAS_MGMT(1'b1), .CORE_REGS(16), .XCVR_REGS(16)) ltra_dev_i (
        .lk(lk), .core_stat(core_stat), .core_ctrl(core_ctrl));
    ltra_ctl ltra_ctl_i (.lk(lk), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    ltra_checker ltra_checker_i (.pclk(pclk), .presetn(presetn),
        .trn_enable(lk.trn_enable), .trn_core_cs(lk.trn_core_cs),
        .trn_xcvr_cs(lk.trn_xcvr_cs), .trn_rnw(lk.trn_rnw),
        .trn_rddata(lk.trn_rddata), .trn_rdack(lk.trn_rdack),
        .trn_wrack(lk.trn_wrack), .cfg_req(lk.cfg_req),
        .cfg_gnt(lk.cfg_gnt), .core_cfg_addr(lk.core_cfg_addr),
        .core_cfg_en(lk.core_cfg_en), .core_cfg_we(lk.core_cfg_we),
        .core_cfg_rdy(lk.core_cfg_rdy), .xcvr_cfg_addr(lk.xcvr_cfg_addr),
        .xcvr_cfg_en(lk.xcvr_cfg_en), .xcvr_cfg_rdy(lk.xcvr_cfg_rdy));

    ////////////////////////////////////////////////////////////////////////
    task give_verdict;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task chk_data(input string what, input logic [DW-1:0] exp, got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task chk_word(input string what, input logic [31:0] exp, got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one apb transfer; request held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // unmatched device address reads 0 on a core access; status index mirrors core_stat
    function automatic logic [DW-1:0] exp_read(logic core, logic [4:0] dv,
                                               logic [3:0] idx);
        if (!core) return xcvr_m[idx];
        if (dv != MGMT_DEVAD) return 16'h0000;
        if (idx == CORE_STAT_IDX) return core_stat;
        return core_m[idx];
    endfunction

    // one training access driven through the controller registers
    task automatic trn_op(input logic rnw, core, xcvr,
                          input logic [20:0] a, input logic [15:0] wd);
        logic [31:0] q;
        int          n;
        int          acks0;
        acks0 = acks;
        apb(1'b1, REG_WDATA, {16'h0000, wd}, q);
        apb(1'b1, REG_ADDR, {11'h000, a}, q);
        apb(1'b1, REG_CMD, {28'h0000000, xcvr, core, rnw, 1'b1}, q);
        n = 0;
        do begin
            apb(1'b0, REG_STATUS, 32'h0, q);
            n++;
        end while (q[ST_DONE] !== 1'b1 && n < 40);
        chk_word("status", 32'h00000002, q);
        if (rnw) begin
            apb(1'b0, REG_RDATA, 32'h0, q);
            chk_data("rddata", exp_read(core, a[20:16], a[3:0]),
                     q[15:0]);
        end else if (!core) begin
            xcvr_m[a[3:0]] = wd;
            chk_data("cfg_wdata", wd, lk.core_cfg_wdata);
        end else if (a[20:16] == MGMT_DEVAD && a[3:0] != CORE_STAT_IDX) begin
            core_m[a[3:0]] = wd;
        end
        if (!core) chk_data("cfg_addr", a[15:0], lk.core_cfg_addr);
        chk_data("core_ctrl", core_m[CORE_CTRL_IDX], core_ctrl);
        chk_word("acks", 32'(acks0 + 1), 32'(acks));
    endtask

    ////////////////////////////////////////////////////////////////////////
    // acknowledge counter and hang guard
    always @(posedge pclk) begin
        cycles++;
        if (lk.trn_rdack === 1'b1 || lk.trn_wrack === 1'b1) acks++;
        if (cycles == 20000) begin
            miscompares++;
            give_verdict;
        end
    end

    initial begin
        seed = 32'hcf0b;
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        core_stat = 16'h5a5a;
        for (int i = 0; i < 16; i++) begin
            core_m[i] = RST_DATA;
            xcvr_m[i] = RST_DATA;
        end
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        chk_data("core_ctrl", RST_DATA, core_ctrl);
        $display("test reset done");
        // status index read-only, foreign device address, both selects
        trn_op(1'b0, 1'b1, 1'b0, {MGMT_DEVAD, 16'h0001}, 16'hbeef);
        trn_op(1'b1, 1'b1, 1'b0, {MGMT_DEVAD, 16'h0001}, 16'h0000);
        trn_op(1'b0, 1'b1, 1'b0, {5'h02, 16'h0000}, 16'h1234);
        trn_op(1'b1, 1'b1, 1'b0, {5'h02, 16'h0000}, 16'h0000);
        trn_op(1'b0, 1'b1, 1'b1, {MGMT_DEVAD, 16'h0000}, 16'h00a5);
        trn_op(1'b0, 1'b0, 1'b1, 21'h0000f, 16'hffff);
        trn_op(1'b1, 1'b0, 1'b1, 21'h0000f, 16'h0000);
        apb(1'b1, 8'h14, 32'hffffffff, c);
        apb(1'b0, 8'h14, 32'h0, c);
        chk_word("unmapped", 32'h0, c);
        $display("test corners done");
        // random mix of spaces, directions and indices
        repeat (30) begin
            core_stat <= 16'($random(seed));
            c = $random(seed);
            trn_op(c[0], c[1], !c[1], {(c[5] & c[4]) ? 5'h03 : MGMT_DEVAD,
                   c[31:20], c[9:6]}, c[27:12]);
        end
        $display("test random done");
        give_verdict;
    end
endmodule
